// ===== design/uab_cnt.sv
//------------------------------------------------------------------------------
// Purpose: free counter that wraps and reports the wrap
// Assumes: clr has priority over en
// Notes:   keeps counting after a wrap
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module uab_cnt #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// control
	input  wire logic         clr,
	input  wire logic         en,
	// state
	output logic [W-1:0]      count,
	output logic              wrap
);

	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;

	always_comb begin
		nxt_count = count_ff;
		if (clr) begin
			nxt_count = '0;
		end else if (en) begin
			nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign count = count_ff;
	assign wrap  = ~clr & en & (&count_ff);

endmodule // uab_cnt

`default_nettype wire

// ===== design/uab_edge.sv
//------------------------------------------------------------------------------
// Purpose: edge detector on the receive line
// Assumes: line already synchronous to clk
// Notes:   line idles high, so the history resets high
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module uab_edge (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// line
	input  wire logic                line,
	// edges, one-cycle pulses
	output uab_pkg::uab_edges_t      edges
);

	logic prev_ff;
	logic nxt_prev;

	always_comb begin
		nxt_prev = line;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prev_ff <= 1'b1;
		end else begin
			prev_ff <= nxt_prev;
		end
	end

	assign edges.rise = line & ~prev_ff;
	assign edges.fall = ~line & prev_ff;

endmodule // uab_edge

`default_nettype wire

// ===== design/uab_pkg.sv
//------------------------------------------------------------------------------
// Purpose: shared constants and types of the receive supervision block
// Assumes: 8-bit register port, one clock, synchronous active-high reset
// Notes:   offsets are used by the top and the bench, field positions by the top only
//------------------------------------------------------------------------------
package uab_pkg;

	//--------------------------------------------------------------------------
	// register port
	//--------------------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] REG_STAT = 3'h1;
	localparam logic [ADDR_W-1:0] REG_DATA = 3'h2;
	localparam logic [ADDR_W-1:0] REG_DIVL = 3'h3;
	localparam logic [ADDR_W-1:0] REG_DIVH = 3'h4;

	//--------------------------------------------------------------------------
	// field positions
	//--------------------------------------------------------------------------
	localparam int CTL_DET_EN  = 0;
	localparam int CTL_WAKE_EN = 1;
	localparam int CTL_IDLE    = 6;
	localparam int CTL_OVF     = 7;
	localparam int STA_IRQ     = 0;
	localparam int STA_IDLE  = 1;

	//--------------------------------------------------------------------------
	// reset values and counts
	//--------------------------------------------------------------------------
	localparam logic [15:0]       DIV_RST    = 16'h0003;
	localparam logic [7:0]        DATA_RST   = 8'h00;
	localparam logic [7:0]        SYNC_DATA  = 8'h55;
	localparam logic [DATA_W-1:0] RD_UNMAP   = 8'h00;
	localparam logic [2:0]        AB_RISES   = 3'h5;
	localparam int                AB_SHIFT   = 3;
	localparam logic [3:0]        BIT_START  = 4'h0;
	localparam logic [3:0]        BIT_STOP   = 4'h9;

	//--------------------------------------------------------------------------
	// types
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} uab_req_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} uab_edges_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_AB_WAIT,
		ST_AB_COUNT,
		ST_RX,
		ST_WAKE_LOW
	} uab_state_t;

endpackage

// ===== design/uab_rx_super.sv
//------------------------------------------------------------------------------
// Purpose: receive supervision: automatic baud detection with overflow,
//          wake on break, and a minimal 8N1 receiver for normal operation
// Assumes: receive_line and sleep_mode synchronous to clk
// Notes:   register read data appear the cycle after the read strobe
//------------------------------------------------------------------------------
// Functional notes
// - Set overflow flag if 16-bit baud counter wraps before fifth rising edge.
// - A baud counter overflow also sets the receive interrupt flag.
// - After overflow the baud counter keeps counting until the fifth rise.
// - Idle flag reads 0 during detection, set at the fifth rising edge.
// - Data read after overflow: fifth rising edge sets interrupt flag again.
// - Detect enable cleared early: remaining falling edges act as start bits.
// - In sleep the baud generator and normal reception stand still.
// - Wake on break works only in asynchronous mode.
// - Wake enable suspends normal reception; block idles watching for wake.
// - A wake event is a high-to-low transition on the receive line.
// - The wake event raises the receive interrupt flag.
// - Reading receive data clears the wake interrupt; software discards value.
// - Rising edge ending the break clears wake enable; block returns idle.
// - Non-zero character under wake enable: first low time is the wake event.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module uab_rx_super (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	// register port
	input  wire uab_pkg::uab_req_t             req,
	output logic [uab_pkg::DATA_W-1:0]         rdata,
	// serial line and mode
	input  wire logic                          receive_line,
	input  wire logic                          sync_mode,
	input  wire logic                          sleep_mode,
	// status
	output logic                               receive_irq_flag,
	output logic                               receive_idle_flag,
	output logic                               baud_detect_overflow_flag
);

	//--------------------------------------------------------------------------
	// state
	//--------------------------------------------------------------------------
	uab_pkg::uab_state_t          st_ff;
	uab_pkg::uab_state_t          nxt_st;
	logic                         det_en_ff;
	logic                         nxt_det_en;
	logic                         wake_en_ff;
	logic                         nxt_wake_en;
	logic                         ovf_ff;
	logic                         nxt_ovf;
	logic                         irq_ff;
	logic                         nxt_irq;
	logic                         idle_ff;
	logic                         nxt_idle;
	logic [15:0]                  div_ff;
	logic [15:0]                  nxt_div;
	logic [7:0]                   data_ff;
	logic [7:0]                   nxt_data;
	logic [7:0]                   shift_ff;
	logic [7:0]                   nxt_shift;
	logic [3:0]                   bit_ff;
	logic [3:0]                   nxt_bit;
	logic [15:0]                  tick_ff;
	logic [15:0]                  nxt_tick;
	logic [2:0]                   rises_ff;
	logic [2:0]                   nxt_rises;
	logic [uab_pkg::DATA_W-1:0]   rdata_ff;
	logic [uab_pkg::DATA_W-1:0]   nxt_rdata;

	//--------------------------------------------------------------------------
	// helpers
	//--------------------------------------------------------------------------
	uab_pkg::uab_edges_t edges;
	logic [15:0]         ab_count;
	logic                ab_wrap;
	logic                ab_clr;
	logic                ab_en;
	logic                wr_ctrl;
	logic                rd_data;
	logic                wake_ok;

	function automatic logic hit(input logic [uab_pkg::ADDR_W-1:0] a,
		input logic [uab_pkg::ADDR_W-1:0] r);
		hit = (a == r);
	endfunction

	assign wr_ctrl = req.wr & hit(req.addr, uab_pkg::REG_CTRL);
	assign rd_data = req.rd & hit(req.addr, uab_pkg::REG_DATA);
	assign wake_ok = wake_en_ff & ~sync_mode;

	uab_edge u_edge (
		.clk   (clk),
		.reset (reset),
		.line  (receive_line),
		.edges (edges)
	);

	// counter runs from the first rise, stands still in sleep
	assign ab_clr = (st_ff == uab_pkg::ST_AB_WAIT);
	assign ab_en  = (st_ff == uab_pkg::ST_AB_COUNT) & ~sleep_mode;

	uab_cnt #(
		.W (16)
	) u_ab_cnt (
		.clk   (clk),
		.reset (reset),
		.clr   (ab_clr),
		.en    (ab_en),
		.count (ab_count),
		.wrap  (ab_wrap)
	);

	//--------------------------------------------------------------------------
	// receive state machine
	//--------------------------------------------------------------------------
	always_comb begin
		nxt_st    = st_ff;
		nxt_shift = shift_ff;
		nxt_bit   = bit_ff;
		nxt_tick  = tick_ff;
		nxt_rises = rises_ff;
		nxt_data  = data_ff;
		nxt_div   = div_ff;
		nxt_det_en  = det_en_ff;
		nxt_wake_en = wake_en_ff;
		nxt_ovf     = ovf_ff;
		nxt_irq     = irq_ff;
		// software side first, hardware events below win
		if (wr_ctrl) begin
			nxt_det_en  = req.wdata[uab_pkg::CTL_DET_EN];
			nxt_wake_en = req.wdata[uab_pkg::CTL_WAKE_EN];
			if (!req.wdata[uab_pkg::CTL_OVF]) begin
				nxt_ovf = 1'b0;
			end
		end
		if (req.wr && hit(req.addr, uab_pkg::REG_DIVL)) begin
			nxt_div[7:0] = req.wdata;
		end
		if (req.wr && hit(req.addr, uab_pkg::REG_DIVH)) begin
			nxt_div[15:8] = req.wdata;
		end
		if (rd_data) begin
			nxt_irq = 1'b0;
		end
		case (st_ff)
			uab_pkg::ST_IDLE: begin
				if (wake_ok && edges.fall) begin
					nxt_irq = 1'b1;
					nxt_st   = uab_pkg::ST_WAKE_LOW;
				end else if (wake_ok || sleep_mode || sync_mode) begin
					nxt_st = uab_pkg::ST_IDLE;
				end else if (det_en_ff && edges.fall) begin
					nxt_st = uab_pkg::ST_AB_WAIT;
				end else if (!det_en_ff && edges.fall) begin
					nxt_tick = {1'b0, div_ff[15:1]};
					nxt_bit  = uab_pkg::BIT_START;
					nxt_st   = uab_pkg::ST_RX;
				end
			end
			uab_pkg::ST_AB_WAIT: begin
				if (!det_en_ff) begin
					nxt_st = uab_pkg::ST_IDLE;
				end else if (edges.rise && !sleep_mode) begin
					nxt_rises = 3'h1;
					nxt_st    = uab_pkg::ST_AB_COUNT;
				end
			end
			uab_pkg::ST_AB_COUNT: begin
				if (ab_wrap) begin
					nxt_ovf  = 1'b1;
					nxt_irq = 1'b1;
				end
				if (!det_en_ff) begin
					nxt_st = uab_pkg::ST_IDLE;
				end else if (edges.rise && !sleep_mode) begin
					nxt_rises = rises_ff + 3'h1;
					if (rises_ff + 3'h1 == uab_pkg::AB_RISES) begin
						// count lags this edge by one clock
						nxt_div    = ((ab_count + 16'h0001)
							>> uab_pkg::AB_SHIFT) - 16'h0001;
						nxt_data   = uab_pkg::SYNC_DATA;
						nxt_det_en = 1'b0;
						nxt_irq    = 1'b1;
						nxt_st    = uab_pkg::ST_IDLE;
					end
				end
			end
			uab_pkg::ST_RX: begin
				if (wake_ok) begin
					nxt_st = uab_pkg::ST_IDLE;
				end else if (!sleep_mode) begin
					if (tick_ff != 16'h0000) begin
						nxt_tick = tick_ff - 16'h0001;
					end else begin
						nxt_tick = div_ff;
						nxt_bit  = bit_ff + 4'h1;
						if (bit_ff == uab_pkg::BIT_START) begin
							if (receive_line) begin
								nxt_st = uab_pkg::ST_IDLE;
							end
						end else if (bit_ff == uab_pkg::BIT_STOP) begin
							nxt_data = shift_ff;
							nxt_irq  = 1'b1;
							nxt_st   = uab_pkg::ST_IDLE;
						end else begin
							nxt_shift = {receive_line, shift_ff[7:1]};
						end
					end
				end
			end
			uab_pkg::ST_WAKE_LOW: begin
				if (edges.rise) begin
					nxt_wake_en = 1'b0;
					nxt_st  = uab_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_st = uab_pkg::ST_IDLE;
			end
		endcase
		nxt_idle = (nxt_st == uab_pkg::ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff    <= uab_pkg::ST_IDLE;
			shift_ff <= uab_pkg::DATA_RST;
			bit_ff   <= uab_pkg::BIT_START;
			tick_ff  <= 16'h0000;
			rises_ff <= 3'h0;
			data_ff  <= uab_pkg::DATA_RST;
			div_ff   <= uab_pkg::DIV_RST;
			det_en_ff  <= 1'b0;
			wake_en_ff <= 1'b0;
			ovf_ff     <= 1'b0;
			irq_ff     <= 1'b0;
			idle_ff  <= 1'b1;
		end else begin
			st_ff    <= nxt_st;
			shift_ff <= nxt_shift;
			bit_ff   <= nxt_bit;
			tick_ff  <= nxt_tick;
			rises_ff <= nxt_rises;
			data_ff  <= nxt_data;
			div_ff   <= nxt_div;
			det_en_ff  <= nxt_det_en;
			wake_en_ff <= nxt_wake_en;
			ovf_ff     <= nxt_ovf;
			irq_ff     <= nxt_irq;
			idle_ff  <= nxt_idle;
		end
	end

	//--------------------------------------------------------------------------
	// read port
	//--------------------------------------------------------------------------
	always_comb begin
		nxt_rdata = uab_pkg::RD_UNMAP;
		if (!req.rd) begin
			nxt_rdata = uab_pkg::RD_UNMAP;
		end else if (hit(req.addr, uab_pkg::REG_CTRL)) begin
			nxt_rdata[uab_pkg::CTL_DET_EN]  = det_en_ff;
			nxt_rdata[uab_pkg::CTL_WAKE_EN] = wake_en_ff;
			nxt_rdata[uab_pkg::CTL_IDLE]  = idle_ff;
			nxt_rdata[uab_pkg::CTL_OVF]   = ovf_ff;
		end else if (hit(req.addr, uab_pkg::REG_STAT)) begin
			nxt_rdata[uab_pkg::STA_IRQ]  = irq_ff;
			nxt_rdata[uab_pkg::STA_IDLE] = idle_ff;
		end else if (hit(req.addr, uab_pkg::REG_DATA)) begin
			nxt_rdata = data_ff;
		end else if (hit(req.addr, uab_pkg::REG_DIVL)) begin
			nxt_rdata = div_ff[7:0];
		end else if (hit(req.addr, uab_pkg::REG_DIVH)) begin
			nxt_rdata = div_ff[15:8];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_ff <= uab_pkg::RD_UNMAP;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata                     = rdata_ff;
	assign receive_irq_flag          = irq_ff;
	assign receive_idle_flag         = idle_ff;
	assign baud_detect_overflow_flag = ovf_ff;

endmodule // uab_rx_super

`default_nettype wire

// ===== tb/tb_uab_rx_super.sv
//------------------------------------------------------------------------------
// Purpose: self-checking bench of the receive supervision block
// Assumes: 10 MHz clock, reset held 16 cycles
// Notes:   the overflow run sends one very slow sync character
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module tb_uab_rx_super;
	logic                          clk;
	logic                          reset;
	uab_pkg::uab_req_t             req;
	logic [uab_pkg::DATA_W-1:0]    rdata;
	logic                          receive_line;
	logic                          sync_mode;
	logic                          sleep_mode;
	logic                          irq;
	logic                          idle;
	logic                          ovf;
	int                            n_fail;
	int                            checks_done;

	uab_rx_super u_dut (
		.clk                       (clk),
		.reset                     (reset),
		.req                       (req),
		.rdata                     (rdata),
		.receive_line              (receive_line),
		.sync_mode                 (sync_mode),
		.sleep_mode                (sleep_mode),
		.receive_irq_flag          (irq),
		.receive_idle_flag         (idle),
		.baud_detect_overflow_flag (ovf)
	);

	uab_remote_tx u_tx (
		.clk  (clk),
		.line (receive_line)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge clk);
		req.wr    <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge clk);
		req.rd   <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	endtask

	task automatic fl(input logic [1:0] e, input string nm);
		`CHK(nm, e, {irq, idle})
	endtask

	task automatic results;
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (95000) @(posedge clk);
		n_fail++;
		results;
	end

	initial begin
		reset = 1'b1;
		req = '0;
		sync_mode = 1'b0;
		sleep_mode = 1'b0;
		n_fail = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		cyc(1);
		//----------------------------------------------------------------------
		// reset values
		//----------------------------------------------------------------------
		rd(uab_pkg::REG_CTRL, 8'h40, "ctrl rst");
		rd(uab_pkg::REG_STAT, 8'h02, "stat rst");
		rd(uab_pkg::REG_DIVL, 8'h03, "divl rst");
		rd(3'h7, 8'h00, "unmapped");
		//----------------------------------------------------------------------
		// baud detection, period 16 clocks
		//----------------------------------------------------------------------
		wr(uab_pkg::REG_CTRL, 8'h01);
		fork
			u_tx.send_byte(uab_pkg::SYNC_DATA, 16);
			begin cyc(40); fl(2'b00, "ab busy"); end
		join
		fl(2'b11, "ab done");
		rd(uab_pkg::REG_CTRL, 8'h40, "ab ctrl");
		rd(uab_pkg::REG_DIVL, 8'h0F, "ab divl");
		rd(uab_pkg::REG_DIVH, 8'h00, "ab divh");
		rd(uab_pkg::REG_DATA, 8'h55, "ab data");
		fl(2'b01, "ab rd clr");
		//----------------------------------------------------------------------
		// detection stopped early: a later fall starts a frame
		//----------------------------------------------------------------------
		wr(uab_pkg::REG_CTRL, 8'h01);
		fork
			u_tx.send_byte(uab_pkg::SYNC_DATA, 16);
			begin cyc(38); wr(uab_pkg::REG_CTRL, 8'h00); end
		join
		cyc(70);
		fl(2'b11, "early irq");
		rd(uab_pkg::REG_DATA, 8'hF5, "early data");
		//----------------------------------------------------------------------
		// normal receive, then receive frozen in sleep
		//----------------------------------------------------------------------
		u_tx.send_byte(8'hA3, 16);
		fl(2'b11, "rx irq");
		rd(uab_pkg::REG_DATA, 8'hA3, "rx data");
		sleep_mode <= 1'b1;
		u_tx.send_byte(8'hA3, 16);
		cyc(20);
		`CHK("sleep rx", 1'b0, irq)
		//----------------------------------------------------------------------
		// wake on break, asleep and awake
		//----------------------------------------------------------------------
		for (int s = 1; s >= 0; s--) begin
			sleep_mode <= s[0];
			wr(uab_pkg::REG_CTRL, 8'h02);
			fork
				u_tx.send_break(13, 16);
				begin cyc(4); fl(2'b10, "wake irq"); end
			join
			fl(2'b11, "wake end");
			rd(uab_pkg::REG_CTRL, 8'h40, "wake clr");
			rd(uab_pkg::REG_DATA, 8'hA3, "wake data");
			fl(2'b01, "wake rd");
		end
		//----------------------------------------------------------------------
		// no wake in synchronous mode
		//----------------------------------------------------------------------
		sync_mode <= 1'b1;
		wr(uab_pkg::REG_CTRL, 8'h02);
		u_tx.send_break(1, 4);
		cyc(30);
		`CHK("sync irq", 1'b0, irq)
		rd(uab_pkg::REG_CTRL, 8'h42, "sync ctrl");
		wr(uab_pkg::REG_CTRL, 8'h00);
		sync_mode <= 1'b0;
		//----------------------------------------------------------------------
		// overflow: counter wraps before the fifth rising edge
		//----------------------------------------------------------------------
		wr(uab_pkg::REG_CTRL, 8'h01);
		fork
			u_tx.send_byte(uab_pkg::SYNC_DATA, 8200);
			begin
				cyc(73745);
				`CHK("ovf set", 1'b1, ovf)
				fl(2'b10, "ovf irq");
				rd(uab_pkg::REG_DATA, 8'hA3, "ovf data");
				fl(2'b00, "ovf rd");
			end
		join
		fl(2'b11, "ovf fifth");
		rd(uab_pkg::REG_CTRL, 8'hC0, "ovf ctrl");
		rd(uab_pkg::REG_DATA, 8'h55, "ovf end");
		wr(uab_pkg::REG_CTRL, 8'h00);
		rd(uab_pkg::REG_CTRL, 8'h40, "ovf clr");
		results;
	end
endmodule // tb_uab_rx_super

`default_nettype wire

// ===== tb/uab_remote_tx.sv
//------------------------------------------------------------------------------
// Purpose: remote asynchronous transmitter driving the receive line
// Assumes: bit period given in clocks per call
// Notes:   line idles high between frames, like a pulled-up wire
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module uab_remote_tx (
	// clock
	input  wire logic clk,
	// serial line
	output logic      line
);
	initial line = 1'b1;

	// 8N1 frame, least significant bit first
	task automatic send_byte(input logic [7:0] b, input int p);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line <= fr[i];
			repeat (p - 1) @(posedge clk);
		end
	endtask

	// all-zero break then idle long enough for start-up
	task automatic send_break(input int bits, input int p);
		@(posedge clk);
		line <= 1'b0;
		repeat (bits * p) @(posedge clk);
		line <= 1'b1;
		repeat (p) @(posedge clk);
	endtask
endmodule // uab_remote_tx

`default_nettype wire

// ===== tb/uab_rx_super_properties.sv
//------------------------------------------------------------------------------
// Purpose: port-level assertions for the receive supervision block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to the top module at the foot of this file
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module uab_rx_super_properties (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      reset,
	// register port
	input wire uab_pkg::uab_req_t         req,
	input wire logic [uab_pkg::DATA_W-1:0] rdata,
	// line and mode
	input wire logic                      receive_line,
	input wire logic                      sleep_mode,
	// status
	input wire logic                      receive_irq_flag,
	input wire logic                      receive_idle_flag,
	input wire logic                      baud_detect_overflow_flag
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	chk_rdata_rest: assert property (
		!$past(req.rd) |-> rdata == 8'h00) else $error("rdata not zero");
	chk_unmapped_read: assert property (
		req.rd && req.addr > uab_pkg::REG_DIVH |=> rdata == uab_pkg::RD_UNMAP)
		else $error("unmapped read not zero");
	chk_stat_flags: assert property (
		req.rd && req.addr == uab_pkg::REG_STAT |=>
		rdata[1:0] == {$past(receive_idle_flag), $past(receive_irq_flag)})
		else $error("status read mismatch");
	chk_ctrl_flags: assert property (
		req.rd && req.addr == uab_pkg::REG_CTRL |=>
		rdata[7:6] == {$past(baud_detect_overflow_flag),
		$past(receive_idle_flag)}) else $error("control read mismatch");
	chk_ovf_irq: assert property (
		$rose(baud_detect_overflow_flag) |-> receive_irq_flag)
		else $error("overflow without irq");
	chk_ovf_sticky: assert property (
		$past(baud_detect_overflow_flag) &&
		!($past(req.wr) && $past(req.addr) == uab_pkg::REG_CTRL)
		|-> baud_detect_overflow_flag) else $error("overflow lost");
	chk_ovf_clear: assert property (
		receive_idle_flag &&
		req.wr && req.addr == uab_pkg::REG_CTRL && !req.wdata[7]
		|=> !baud_detect_overflow_flag) else $error("overflow not cleared");
	chk_idle_fall: assert property (
		$fell(receive_idle_flag) |->
		!$past(receive_line) || !$past(receive_line, 2))
		else $error("idle fell without line low");
	chk_sleep_wake: assert property (
		$rose(receive_irq_flag) && $past(sleep_mode) |-> !$past(receive_line))
		else $error("irq in sleep without wake");
endmodule // uab_rx_super_properties

bind uab_rx_super uab_rx_super_properties u_chk (
	.clk                       (clk),
	.reset                     (reset),
	.req                       (req),
	.rdata                     (rdata),
	.receive_line              (receive_line),
	.sleep_mode                (sleep_mode),
	.receive_irq_flag          (receive_irq_flag),
	.receive_idle_flag         (receive_idle_flag),
	.baud_detect_overflow_flag (baud_detect_overflow_flag)
);

`default_nettype wire
